// ### mtx_defs.svh
// Constants of the transmit and loopback block: offsets, fields, resets, timing
`ifndef MTX_DEFS_SVH
`define MTX_DEFS_SVH
// ****************************************
// Register offsets on the 4-bit address port
// ****************************************
`define MTX_A_CMD     4'h0
`define MTX_A_PSTART  4'h1
`define MTX_A_CNTLO   4'h2
`define MTX_A_CNTHI   4'h3
`define MTX_A_TCFG    4'h4
`define MTX_A_DCFG    4'h5
`define MTX_A_TSTAT   4'h6
`define MTX_A_NCOL    4'h7
`define MTX_A_ISTAT   4'h8
`define MTX_A_LBPORT  4'h9
`define MTX_A_LBSTAT  4'hA
// ****************************************
// Field positions
// ****************************************
`define MTX_CMD_TXP   0
`define MTX_TCFG_INH  0
`define MTX_TCFG_LB   2:1
`define MTX_DCFG_WTS  0
`define MTX_DCFG_BOS  1
`define MTX_TST_PTX   0
`define MTX_TST_COL   2
`define MTX_TST_ABT   3
`define MTX_IST_PTX   1
`define MTX_IST_TXE   3
`define MTX_LBS_AM    0
`define MTX_LBS_CRC   1
// Loop select codes
`define MTX_LB_CORE   2'h1
`define MTX_LB_ENDEC  2'h2
`define MTX_LB_XCVR   2'h3
// ****************************************
// Reset values, CRC constants, collision and FIFO limits
// ****************************************
`define MTX_TCFG_RST  3'h0
`define MTX_DCFG_RST  2'h0
`define MTX_CRC_INIT  32'hFFFFFFFF
`define MTX_CRC_POLY  32'hEDB88320
`define MTX_CRC_RES   32'hDEBB20E3
`define MTX_MAX_COL   4'hF
`define MTX_FIFO_FULL 5'h10
`define MTX_FIFO_HALF 5'h08
// ****************************************
// Timing
// ****************************************
`define MTX_CLK_MHZ   200
`define MTX_BIT_NS    100
`define MTX_BIT_CYC   (`MTX_BIT_NS * `MTX_CLK_MHZ / 1000)
`define MTX_IFG_NS    6400
`define MTX_IFG_BITS  (`MTX_IFG_NS / `MTX_BIT_NS)
`define MTX_PRE_BITS  64
`define MTX_SLOT_BITS 512
`endif

// ### mtx_pkg.sv
// Types of the transmit and loopback block
package mtx_pkg;
	// Transmit sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_DEFER, ST_RECV, ST_PRE, ST_DATA, ST_FCS, ST_BOFF}
		mtx_st_type;
	// Buffer memory request toward the arbiter
	typedef struct packed {
		logic        req;
		logic        word;
		logic [15:0] addr;
	} mtx_mreq_type;
	// Whole state of the block
	typedef struct packed {
		mtx_st_type       st;
		logic [4:0]       tick;
		logic [6:0]       ifg;
		logic [18:0]      bo;
		logic [9:0]       lfsr;
		logic [7:0]       psr;
		logic [15:0]      cnt, fcnt, faddr;
		logic             fetching, mem_word;
		logic [15:0][7:0] fifo;
		logic [4:0]       wp, rp;
		logic [7:0]       sh;
		logic [5:0]       bn;
		logic [31:0]      crc, rxcrc;
		logic [2:0]       transmit_config_reg;
		logic [1:0]       data_config_reg;
		logic [7:0]       transmit_status_reg, interrupt_status_reg;
		logic [3:0]       collision_count_reg;
		logic [7:0][7:0]  ring;
		logic [2:0]       rwp, rrp, rxn;
		logic             amatch;
		logic [1:0]       rsr;
		logic [7:0]       rdata;
		logic             tx_en, tx_bit;
		logic             crs_m, crs_s, col_m, col_s, rxa_m, rxa_s, ws_m, ws_s;
	} mtx_regs_type;
endpackage

// ### mtx_top.sv
// Transmit path with preamble, CRC, collision retry and loopback capture
`include "mtx_defs.svh"
// Behaviour
// - DMA fetches frame from start page, count
// - Preamble, sync and CRC generated internally
// - Byte count excludes preamble and CRC
// - Core width from word select and pin
// - Transmit command clears status, starts prefetch
// - Start needs gap, FIFO byte, backoff done
// - Carrier before first byte means receive
// - Collision resets FIFO, rewinds, counts
// - Sixteenth collision aborts, count reads zero
// - Byte order selects lane of even bytes
// - Ascending bytes, least significant bit first
// - Loopback halves the FIFO
// - Loopback fetches one byte per transfer
// - Last eight looped bytes read sequentially
// - Loopback checks address match and CRC
// - CRC appended only when inhibit clear
// - Loop select picks internal, encoder, cable
// - Frame sent flag set at end
module mtx_top (
	// Clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rstn,
	// Register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [7:0]           reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic [7:0]                reg_rdata,
	// Buffer memory
	output mtx_pkg::mtx_mreq_type     mreq,
	input  wire logic                 mem_gnt,
	input  wire logic [15:0]          mem_rdata,
	// Serial link and loop controls
	output logic                      tx_en,
	output logic                      tx_bit,
	input  wire logic                 crs,
	input  wire logic                 col,
	input  wire logic                 rx_active,
	output logic                      endec_loop,
	output logic                      xcvr_loop,
	// Straps and station identity
	input  wire logic                 width_select_pin,
	input  wire logic [47:0]          station_addr
);
	// ****************************************
	// State and helpers
	// ****************************************
	mtx_pkg::mtx_regs_type s;      // Registered state
	mtx_pkg::mtx_regs_type n;      // Next state
	logic [9:0]            bo_mask; // Backoff window
	logic                  col_ev;  // Collision taken this cycle

	// One CRC bit step, reflected polynomial
	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic b);
		crc_step = (c[0] ^ b) ? ((c >> 1) ^ `MTX_CRC_POLY) : (c >> 1);
	endfunction

	// Backoff window grows with each collision, capped at ten bits
	genvar gi;
	generate
		for (gi = 0; gi < 10; gi++)
		begin : g_mask
			assign bo_mask[gi] = (4'(gi) <= s.collision_count_reg);
		end
	endgenerate

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb
	begin
		logic       tick, lb_on, ext, crs_e, fin, fcs_now, emit, ebit, full, inh, word_transfer_select, byte_order_select;
		logic [4:0] lvl, cap;
		logic [7:0] b0, b1, pb;
		logic [5:0] nb;
		logic [1:0] lb;
		n = s;
		lb = s.transmit_config_reg[`MTX_TCFG_LB];
		lb_on = (lb != 2'h0);
		ext = (lb != `MTX_LB_CORE);
		inh = s.transmit_config_reg[`MTX_TCFG_INH];
		word_transfer_select = s.data_config_reg[`MTX_DCFG_WTS];
		byte_order_select = s.data_config_reg[`MTX_DCFG_BOS];
		fin = 1'b0;
		fcs_now = 1'b0;
		emit = 1'b0;
		ebit = 1'b0;
		pb = 8'h00;
		nb = 6'h00;
		// Pin synchronisers
		n.crs_m = crs;
		n.crs_s = s.crs_m;
		n.col_m = col;
		n.col_s = s.col_m;
		n.rxa_m = rx_active;
		n.rxa_s = s.rxa_m;
		n.ws_m = width_select_pin;
		n.ws_s = s.ws_m;
		// Internal loop hides the medium's carrier and collision
		crs_e = s.crs_s & ext;
		col_ev = s.col_s & ext & (s.st inside {mtx_pkg::ST_PRE, mtx_pkg::ST_DATA,
			mtx_pkg::ST_FCS});
		// Bit time base and free running noise source
		tick = (s.tick == 5'(`MTX_BIT_CYC - 1));
		n.tick = tick ? 5'h00 : 5'(s.tick + 5'h01);
		n.lfsr = {s.lfsr[8:0], ~(s.lfsr[9] ^ s.lfsr[6])};
		// Interframe gap runs only while the wire is quiet
		if (s.tx_en || crs_e)
			n.ifg = 7'h00;
		else if (tick && s.ifg < 7'(`MTX_IFG_BITS))
			n.ifg = 7'(s.ifg + 7'h01);
		// Core width from word select and width pin
		n.mem_word = word_transfer_select & s.ws_s;
		// ********** FIFO fill **********
		lvl = 5'(s.wp - s.rp);
		cap = lb_on ? `MTX_FIFO_HALF : `MTX_FIFO_FULL;
		full = (5'(cap - lvl) < 5'h02);
		b0 = s.mem_word ? (byte_order_select ? mem_rdata[15:8] : mem_rdata[7:0]) : mem_rdata[7:0];
		b1 = byte_order_select ? mem_rdata[7:0] : mem_rdata[15:8];
		if (s.fetching && mem_gnt)
		begin
			// One grant moves one word or one byte
			n.fifo[s.wp[3:0]] = b0;
			n.wp = 5'(s.wp + 5'h01);
			if (s.mem_word && !lb_on && s.fcnt > 16'h0001)
			begin
				n.fifo[4'(s.wp + 5'h01)] = b1;
				n.wp = 5'(s.wp + 5'h02);
			end
			// Word loopback takes one lane, count still drops by two
			n.fcnt = (s.mem_word && s.fcnt > 16'h0001) ? 16'(s.fcnt - 16'h0002)
				: 16'(s.fcnt - 16'h0001);
			n.faddr = 16'(s.faddr + (s.mem_word ? 16'h0002 : 16'h0001));
			n.fetching = 1'b0;
		end
		else if (!s.fetching)
			// Fetch when room, no reception in progress, and bytes left
			n.fetching = (s.st inside {mtx_pkg::ST_DEFER, mtx_pkg::ST_PRE, mtx_pkg::ST_DATA})
				&& s.fcnt != 16'h0000 && !s.rxa_s && !full;
		// ********** Sequencer **********
		unique case (s.st)
			mtx_pkg::ST_IDLE:
			begin
				if (reg_wr && reg_addr == `MTX_A_CMD && reg_wdata[`MTX_CMD_TXP])
				begin
					n.transmit_status_reg = 8'h00;
					n.collision_count_reg = 4'h0;
					n.fcnt = s.cnt;
					n.faddr = {s.psr, 8'h00};
					n.wp = 5'h00;
					n.rp = 5'h00;
					n.rwp = 3'h0;
					n.st = mtx_pkg::ST_DEFER;
				end
			end
			mtx_pkg::ST_DEFER:
			begin
				if (crs_e && s.wp == s.rp)
					n.st = mtx_pkg::ST_RECV;
				else if (s.ifg >= 7'(`MTX_IFG_BITS) && s.wp != s.rp && tick)
				begin
					// Gap done, a byte waits, backoff already served
					n.st = mtx_pkg::ST_PRE;
					n.bn = 6'h00;
					n.crc = `MTX_CRC_INIT;
					n.rxcrc = `MTX_CRC_INIT;
					n.amatch = 1'b1;
					n.rxn = 3'h0;
				end
			end
			mtx_pkg::ST_RECV:
			begin
				if (!crs_e)
					n.st = mtx_pkg::ST_DEFER;
			end
			mtx_pkg::ST_BOFF:
			begin
				if (s.bo == 19'h00000)
					n.st = mtx_pkg::ST_DEFER;
				else if (tick)
					n.bo = 19'(s.bo - 19'h00001);
			end
			mtx_pkg::ST_PRE:
			begin
				if (tick)
				begin
					// Alternating ones and zeros, last two bits both one
					n.tx_bit = (s.bn == 6'(`MTX_PRE_BITS - 1)) | ~s.bn[0];
					n.bn = 6'(s.bn + 6'h01);
					if (s.bn == 6'(`MTX_PRE_BITS - 1))
					begin
						n.st = mtx_pkg::ST_DATA;
						n.bn = 6'h00;
					end
				end
			end
			mtx_pkg::ST_DATA:
			begin
				if (tick && s.bn[2:0] == 3'h0)
				begin
					if (s.wp != s.rp)
					begin
						// Next byte in ascending order, bit 0 first
						pb = s.fifo[s.rp[3:0]];
						emit = 1'b1;
						ebit = pb[0];
						n.sh = {1'b0, pb[7:1]};
						n.rp = 5'(s.rp + 5'h01);
						n.bn = 6'h01;
						if (lb_on)
						begin
							n.ring[s.rwp] = pb;
							n.rwp = 3'(s.rwp + 3'h1);
						end
						if (s.rxn < 3'h6)
						begin
							n.amatch = s.amatch & (pb == station_addr[8 * s.rxn +: 8]);
							n.rxn = 3'(s.rxn + 3'h1);
						end
					end
					else if (s.fcnt == 16'h0000 && !s.fetching)
					begin
						if (inh)
							fin = 1'b1;
						else
						begin
							n.st = mtx_pkg::ST_FCS;
							fcs_now = 1'b1;
						end
					end
				end
				else if (tick)
				begin
					emit = 1'b1;
					ebit = s.sh[0];
					n.sh = {1'b0, s.sh[7:1]};
					n.bn = {3'h0, 3'(s.bn[2:0] + 3'h1)};
				end
				if (emit)
					n.crc = crc_step(s.crc, ebit);
			end
			mtx_pkg::ST_FCS:
			begin
				fcs_now = tick;
				nb = s.bn;
			end
		endcase
		// Frame check sequence, complemented, low bit first
		// The last bit stands a full bit time before the frame ends
		if (fcs_now && nb == 6'h20)
			fin = 1'b1;
		else if (fcs_now)
		begin
			emit = 1'b1;
			ebit = ~s.crc[0];
			n.crc = {1'b1, s.crc[31:1]};
			n.sh = {ebit, s.sh[7:1]};
			n.bn = 6'(nb + 6'h01);
			if (nb[2:0] == 3'h7 && lb_on)
			begin
				n.ring[s.rwp] = {ebit, s.sh[7:1]};
				n.rwp = 3'(s.rwp + 3'h1);
			end
		end
		if (emit)
		begin
			n.tx_bit = ebit;
			if (lb_on)
				n.rxcrc = crc_step(s.rxcrc, ebit);
		end
		// End of frame: status, flag and read-back start
		if (fin)
		begin
			n.st = mtx_pkg::ST_IDLE;
			n.transmit_status_reg[`MTX_TST_PTX] = 1'b1;
			n.interrupt_status_reg[`MTX_IST_PTX] = 1'b1;
			n.rrp = n.rwp;
			n.rsr = {~inh && (n.rxcrc != `MTX_CRC_RES), n.amatch};
		end
		// ********** Collision **********
		if (col_ev)
		begin
			n.transmit_status_reg[`MTX_TST_COL] = 1'b1;
			n.wp = 5'h00;
			n.rp = 5'h00;
			n.fcnt = s.cnt;
			n.faddr = {s.psr, 8'h00};
			n.fetching = 1'b0;
			if (s.collision_count_reg == `MTX_MAX_COL)
			begin
				n.transmit_status_reg[`MTX_TST_ABT] = 1'b1;
				n.interrupt_status_reg[`MTX_IST_TXE] = 1'b1;
				n.collision_count_reg = 4'h0;
				n.st = mtx_pkg::ST_IDLE;
			end
			else
			begin
				n.collision_count_reg = 4'(s.collision_count_reg + 4'h1);
				n.bo = 19'(s.lfsr & bo_mask) * 19'(`MTX_SLOT_BITS);
				n.st = mtx_pkg::ST_BOFF;
			end
		end
		n.tx_en = (n.st inside {mtx_pkg::ST_PRE, mtx_pkg::ST_DATA, mtx_pkg::ST_FCS});
		// ********** Register port **********
		if (reg_wr)
		begin
			unique case (reg_addr)
				`MTX_A_PSTART: n.psr = reg_wdata;
				`MTX_A_CNTLO:  n.cnt[7:0] = reg_wdata;
				`MTX_A_CNTHI:  n.cnt[15:8] = reg_wdata;
				`MTX_A_TCFG:   n.transmit_config_reg = reg_wdata[2:0];
				`MTX_A_DCFG:   n.data_config_reg = reg_wdata[1:0];
				// Write one clears, a new event wins only on a bit that was clear
				`MTX_A_ISTAT:  n.interrupt_status_reg = (s.interrupt_status_reg & ~reg_wdata) | (n.interrupt_status_reg & ~s.interrupt_status_reg);
				default:       n.interrupt_status_reg = n.interrupt_status_reg;
			endcase
		end
		n.rdata = 8'h00;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`MTX_A_CMD:    n.rdata = {7'h00, s.st != mtx_pkg::ST_IDLE};
				`MTX_A_PSTART: n.rdata = s.psr;
				`MTX_A_CNTLO:  n.rdata = s.cnt[7:0];
				`MTX_A_CNTHI:  n.rdata = s.cnt[15:8];
				`MTX_A_TCFG:   n.rdata = {5'h00, s.transmit_config_reg};
				`MTX_A_DCFG:   n.rdata = {6'h00, s.data_config_reg};
				`MTX_A_TSTAT:  n.rdata = s.transmit_status_reg;
				`MTX_A_NCOL:   n.rdata = {4'h0, s.collision_count_reg};
				`MTX_A_ISTAT:  n.rdata = s.interrupt_status_reg;
				`MTX_A_LBSTAT: n.rdata = {6'h00, s.rsr};
				`MTX_A_LBPORT:
				begin
					n.rdata = s.ring[s.rrp];
					n.rrp = 3'(s.rrp + 3'h1);
				end
				default:       n.rdata = 8'h00;
			endcase
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			s <= '0;
		else
			s <= n;
	end

	// Outputs: tx_en suppressed in internal loop, tx_bit still driven
	assign reg_rdata = s.rdata;
	assign mreq = '{req: s.fetching, word: s.mem_word, addr: s.faddr};
	assign tx_en = s.tx_en & (s.transmit_config_reg[`MTX_TCFG_LB] != `MTX_LB_CORE);
	assign tx_bit = s.tx_bit;
	assign endec_loop = (s.transmit_config_reg[`MTX_TCFG_LB] == `MTX_LB_ENDEC);
	assign xcvr_loop = (s.transmit_config_reg[`MTX_TCFG_LB] == `MTX_LB_XCVR);

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Cycles spent in the preamble, too many for a delay range
	logic [10:0] pre_len_q;
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			pre_len_q <= 11'h000;
		else if (s.st == mtx_pkg::ST_PRE)
			pre_len_q <= 11'(pre_len_q + 11'h001);
		else
			pre_len_q <= 11'h000;
	end
	// Preamble hands over to data without a collision
	sequence pre_leave;
		(s.st == mtx_pkg::ST_PRE && n.st == mtx_pkg::ST_DATA);
	endsequence
	// Exactly the full preamble has gone by, then data follows
	sequence pre_full;
		(pre_len_q == 11'(`MTX_PRE_BITS * `MTX_BIT_CYC - 1)) ##1 (s.st == mtx_pkg::ST_DATA);
	endsequence
	start_clears_a: assert property ((s.st == mtx_pkg::ST_IDLE && reg_wr && reg_addr == `MTX_A_CMD && reg_wdata[0]) |=> (s.st == mtx_pkg::ST_DEFER && s.transmit_status_reg == 8'h00)) else $error("transmit command not taken");
	fetch_hold_a: assert property ((s.rxa_s && !s.fetching) |=> !s.fetching) else $error("fetch during reception");
	start_cond_a: assert property ((s.st == mtx_pkg::ST_DEFER && n.st == mtx_pkg::ST_PRE) |-> (s.ifg >= 7'h40 && s.wp != s.rp)) else $error("start without gap or byte");
	carrier_rx_a: assert property ((s.st == mtx_pkg::ST_DEFER && s.crs_s && s.transmit_config_reg[2:1] != 2'h1 && s.wp == s.rp) |=> s.st == mtx_pkg::ST_RECV) else $error("carrier not yielded");
	col_rewind_a: assert property ((col_ev && s.collision_count_reg != 4'hF) |=> (s.wp == 5'h00 && s.fcnt == s.cnt && s.transmit_status_reg[2] && s.collision_count_reg == $past(s.collision_count_reg) + 4'h1)) else $error("collision recovery wrong");
	col_abort_a: assert property ((col_ev && s.collision_count_reg == 4'hF) |=> (s.transmit_status_reg[3] && s.collision_count_reg == 4'h0 && s.st == mtx_pkg::ST_IDLE)) else $error("excess collision abort wrong");
	preamble_len_a: assert property (pre_leave |-> pre_full) else $error("preamble length wrong");
	preamble_max_a: assert property ((s.st == mtx_pkg::ST_PRE) |-> (pre_len_q <= 11'(`MTX_PRE_BITS * `MTX_BIT_CYC - 1))) else $error("preamble too long");
	split_fifo_a: assert property ((s.transmit_config_reg[2:1] != 2'h0) |-> (5'(s.wp - s.rp) <= 5'h08)) else $error("loopback FIFO half exceeded");
	fetch_count_a: assert property ((s.fetching && mem_gnt && !col_ev) |=> (s.fcnt < $past(s.fcnt))) else $error("count not decremented");
	crc_inhibit_a: assert property ((s.st == mtx_pkg::ST_FCS) |-> !s.transmit_config_reg[0]) else $error("CRC sent while inhibited");
	sent_flag_a: assert property ((s.st inside {mtx_pkg::ST_DATA, mtx_pkg::ST_FCS} && n.st == mtx_pkg::ST_IDLE && !col_ev) |=> (s.interrupt_status_reg[1] && !s.tx_en)) else $error("frame sent flag missing");
endmodule

// ### mtx_mem_model.sv
// Buffer memory model that answers transmit fetches after a settable delay
module mtx_mem_model (
	// Clock and reset
	input  wire logic                  mclk,
	input  wire logic                  rstn,
	// Fetch request, delay setting and answer
	input  wire mtx_pkg::mtx_mreq_type mreq,
	input  wire logic [3:0]            max_wait,
	output logic                       mem_gnt,
	output logic [15:0]                mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535]; // Byte store filled by the host tasks
	logic [3:0] wait_q;        // Cycles left before the next grant
	logic [7:0] b0, b1;        // Lanes of the addressed location
	assign b0 = mem[mreq.addr];
	assign b1 = mreq.word ? mem[mreq.addr + 16'h1] : ~b0;
	// One grant per request; lines keep toggling while nothing is granted
	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			mem_gnt   <= 1'b0;
			mem_rdata <= 16'h5A5A;
			wait_q    <= 4'h0;
		end
		else if (mreq.req && !mem_gnt && wait_q == 4'h0)
		begin
			// Worst delay stays far inside the access latency limit
			mem_gnt   <= 1'b1;
			mem_rdata <= {b1, b0};
			wait_q    <= max_wait;
		end
		else
		begin
			// Released data lines never hold the last value
			mem_gnt   <= 1'b0;
			mem_rdata <= ~mem_rdata;
			wait_q    <= (mreq.req && wait_q != 4'h0) ? wait_q - 4'h1 : wait_q;
		end
	end
endmodule

// ### mtx_tb_top.sv
// Self-checking bench for the transmit and loopback block
`include "mtx_defs.svh"
module mtx_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ****************
	// Signals
	// ****************
	logic                  mclk, rstn, reg_wr, reg_rd, mem_gnt, tx_en, tx_bit;
	logic                  crs, col, rx_active, endec_loop, xcvr_loop, width_select_pin;
	logic [3:0]            reg_addr, mem_wait;
	logic [7:0]            reg_wdata, reg_rdata, v;
	logic [15:0]           mem_rdata;
	logic [47:0]           station_addr;
	mtx_pkg::mtx_mreq_type mreq;
	int                    n_errors, tests_run, seed, n_gnt;
	logic                  last_word, saw_tx;
	// Clock of 5 ns
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	mtx_top u_mtx_top (.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mreq(mreq),
		.mem_gnt(mem_gnt), .mem_rdata(mem_rdata), .tx_en(tx_en), .tx_bit(tx_bit), .crs(crs),
		.col(col), .rx_active(rx_active), .endec_loop(endec_loop), .xcvr_loop(xcvr_loop),
		.width_select_pin(width_select_pin), .station_addr(station_addr));
	mtx_mem_model u_mtx_mem_model (.mclk(mclk), .rstn(rstn), .mreq(mreq),
		.max_wait(mem_wait), .mem_gnt(mem_gnt), .mem_rdata(mem_rdata));
	// Count fetches and note any line activity
	always @(posedge mclk)
	begin
		if (mreq.req === 1'b1 && mem_gnt === 1'b1)
		begin
			n_gnt++;
			last_word = mreq.word;
		end
		if (tx_en === 1'b1)
			saw_tx = 1'b1;
	end
	// ****************
	// Tasks
	// ****************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	// Frame check value, reflected polynomial, complemented
	function automatic logic [31:0] fcs(input logic [7:0] b[$]);
		logic [31:0] c;
		c = 32'hFFFFFFFF;
		foreach (b[i])
			for (int k = 0; k < 8; k++)
				c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? 32'hEDB88320 : 32'h0);
		return ~c;
	endfunction
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One frame: store, program, send, then compare with the model
	task automatic run(input int n, input bit word_transfer_select, byte_order_select, lb, inh, hit, hold, coll);
		logic [7:0]  fr[$];
		logic        exp_b[$];
		logic        bits[$];
		logic [31:0] c;
		int          a, k;
		for (int i = 0; i < n; i++)
			fr.push_back((i < 6 && hit) ? station_addr[8*i +: 8] : 8'($random(seed)));
		c = fcs(fr);
		for (int i = 0; i < n; i++)
		begin
			a = (lb && word_transfer_select) ? 2 * i + int'(byte_order_select) : (word_transfer_select ? i ^ int'(byte_order_select) : i);
			u_mtx_mem_model.mem[16'h0100 + 16'(a)] = fr[i];
			if (lb && word_transfer_select)
				u_mtx_mem_model.mem[16'h0100 + 16'(a ^ 1)] = ~fr[i];
		end
		if (!inh)
			for (int i = 0; i < 4; i++)
				fr.push_back(c[8*i +: 8]);
		k = (lb && word_transfer_select) ? 2 * n : n;
		width_select_pin <= word_transfer_select;
		wr(4'h1, 8'h01);
		wr(4'h2, 8'(k));
		wr(4'h3, 8'(k >> 8));
		wr(4'h4, {5'h0, lb ? 2'h1 : 2'h0, inh});
		wr(4'h5, {6'h0, byte_order_select, word_transfer_select});
		crs       <= hold;
		rx_active <= hold;
		n_gnt  = 0;
		saw_tx = 1'b0;
		wr(4'h0, 8'h01);
		rd(4'h6, v);
		chk(v, 8'h00);
		if (hold)
		begin
			repeat (300) @(posedge mclk);
			chk({mreq.req, tx_en}, 2'b00);
			crs       <= 1'b0;
			rx_active <= 1'b0;
		end
		if (coll)
		begin
			for (k = 0; k < 4000 && tx_en !== 1'b1; k++)
				@(posedge mclk);
			repeat (1500) @(posedge mclk);
			col <= 1'b1;
			repeat (4) @(posedge mclk);
			col <= 1'b0;
			for (k = 0; k < 3000 && tx_en !== 1'b0; k++)
				@(posedge mclk);
			rd(4'h6, v);
			chk(v & 8'h04, 8'h04);
		end
		if (!lb)
		begin
			// First bit stands one bit time after tx_en rises; sample mid-bit on falling edges
			for (k = 0; k < 30000 && tx_en !== 1'b1; k++)
				@(negedge mclk);
			repeat (`MTX_BIT_CYC + `MTX_BIT_CYC / 2 - 1) @(negedge mclk);
			while (tx_en === 1'b1)
			begin
				bits.push_back(tx_bit);
				repeat (`MTX_BIT_CYC) @(negedge mclk);
			end
			for (int i = 0; i < 64; i++)
				exp_b.push_back(i == 63 || i % 2 == 0);
			foreach (fr[i])
				for (int j = 0; j < 8; j++)
					exp_b.push_back(fr[i][j]);
			chk(bits.size(), exp_b.size());
			foreach (exp_b[i])
				chk(i < bits.size() ? bits[i] : 1'bx, exp_b[i]);
		end
		v = 8'h01;
		for (k = 0; k < 20000 && v[0] !== 1'b0; k++)
			rd(4'h0, v);
		chk(v, 8'h00);
		if (lb)
		begin
			chk({saw_tx, 16'(n_gnt)}, {1'b0, 16'(n)});
			for (int i = 0; i < 8; i++)
			begin
				rd(4'h9, v);
				chk(v, fr[fr.size() - 8 + i]);
			end
			rd(4'hA, v);
			chk(v, {7'h0, hit});
		end
		else
		begin
			rd(4'h6, v);
			chk(v, coll ? 8'h05 : 8'h01);
			rd(4'h7, v);
			chk(v, 8'(coll));
			if (!coll)
				chk({last_word, 16'(n_gnt)}, {word_transfer_select, 16'(word_transfer_select ? n / 2 : n)});
		end
		rd(4'h8, v);
		chk(v & 8'h02, 8'h02);
		wr(4'h8, 8'h0A);
		rd(4'h8, v);
		chk(v, 8'h00);
		$display("test done n=%0d wts=%0d bos=%0d lb=%0d", n, word_transfer_select, byte_order_select, lb);
	endtask
	// ****************
	// Main sequence
	// ****************
	initial
	begin
		seed = 32'h1d51;
		n_errors = 0;
		tests_run = 0;
		n_gnt = 0;
		saw_tx = 1'b0;
		rstn = 1'b0;
		{reg_wr, reg_rd, crs, col, rx_active, width_select_pin} = 6'h00;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		mem_wait = 4'h0;
		station_addr = 48'({$random(seed), $random(seed)});
		repeat (12) @(posedge mclk);
		rstn <= 1'b1;
		// Reset values and an unmapped index read as zero
		for (int i = 4; i < 9; i++)
		begin
			rd(4'(i), v);
			chk(v, 8'h00);
		end
		rd(4'hF, v);
		chk(v, 8'h00);
		// Every loop select code
		for (int i = 0; i < 4; i++)
		begin
			wr(4'h4, 8'(i << 1));
			rd(4'h4, v);
			chk({v, endec_loop, xcvr_loop}, {8'(i << 1), 1'(i == 2), 1'(i == 3)});
		end
		$display("test done registers");
		run(64, 0, 0, 0, 0, 0, 1, 0);
		mem_wait <= 4'h7;
		run(64, 1, 1, 0, 1, 0, 0, 0);
		mem_wait <= 4'h2;
		run(64, 1, 0, 0, 0, 0, 0, 1);
		for (int b = 0; b < 2; b++)
			run(20, 1, b, 1, 0, b == 0, 0, 0);
		wrap_up();
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		repeat (90000) @(posedge mclk);
		n_errors++;
		wrap_up();
	end
endmodule
